// File: src/stream_buffer.sv
// small shifting fifo that decouples received words from a stalling reader
`timescale 1ns/1ps
module stream_buffer #(
   parameter int W = 8,
   parameter int DEPTH = 2
) (
   // clock and synchronised reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // filling and draining sides
   stream_if.sink push,
   stream_if.source pop
);
   localparam int CW = $clog2(DEPTH + 1);

   // whole state: entries, fill count and a registered valid
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] slot;
      logic [CW-1:0] cnt;
      logic vld;
   } buf_t;

   buf_t st, next_st;
   logic do_push; // word taken this cycle
   logic do_pop; // head handed out this cycle
   logic [CW-1:0] wr; // write index after any pop

   // ready only while an entry is free, so full is honest
   assign push.ready = (st.cnt != CW'(DEPTH));
   assign pop.valid = st.vld;
   assign pop.data = st.slot[0];

   // next state: shift out the head, append the new word behind the rest
   always_comb begin
      next_st = st;
      do_pop = st.vld && pop.ready;
      do_push = push.valid && push.ready;
      wr = st.cnt - CW'(do_pop);
      if (do_pop) begin
         for (int i = 0; i < DEPTH - 1; i++) begin
            next_st.slot[i] = st.slot[i+1];
         end
      end
      if (do_push) begin
         next_st.slot[wr] = push.data;
      end
      next_st.cnt = wr + CW'(do_push);
      next_st.vld = (next_st.cnt != '0);
   end

   // state register
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   a_buf_full_refuse: assert property (
      (st.cnt == CW'(DEPTH)) |-> !push.ready)
      else $error("buffer took a word while full");
   a_buf_head_holds: assert property (
      (pop.valid && !pop.ready) |=> (pop.valid && $stable(pop.data)))
      else $error("stalled head word changed or vanished");
endmodule

// File: src/stream_if.sv
// valid/ready stream carrier between the block's own modules
`timescale 1ns/1ps
interface stream_if #(parameter int W = 8);
   logic valid; // source offers data
   logic ready; // sink takes data
   logic [W-1:0] data;
   modport source (output valid, output data, input ready);
   modport sink (input valid, input data, output ready);
endinterface

// File: src/tdm_pkg.sv
// shared constants, types and helpers for the tdm slot channel access block
package tdm_pkg;
   // structure of the highway and the channels
   localparam int CH_N = 4; // serial channels
   localparam int POS_W = 8; // slot position register width
   localparam int CNT_W = 9; // bit counter, covers frames up to 512 bits
   localparam int WSEL_W = 2; // slot width select field
   localparam int LEN_W = 4; // slot length in bits
   localparam int BYTE_W = 8; // bits per channel per frame on the transmit side
   localparam int OFF_W = 3; // bit index inside a channel byte
   localparam int BUF_DEPTH = 2; // entries of the receive buffer
   localparam int MARK_CH = 1; // second controller owns the slot marker

   // connection mode codes {hi, lo}
   localparam logic [1:0] MODE_SINGLE_TS = 2'h0;
   localparam logic [1:0] MODE_QUAD_CC = 2'h1;
   localparam logic [1:0] MODE_SINGLE_IOM = 2'h2;
   localparam logic [1:0] MODE_QUAD_TS = 2'h3;

   // slot width select codes and the lengths they give
   localparam logic [WSEL_W-1:0] WSEL_1 = 2'h0;
   localparam logic [WSEL_W-1:0] WSEL_2 = 2'h1;
   localparam logic [WSEL_W-1:0] WSEL_7 = 2'h2;
   localparam logic [WSEL_W-1:0] WSEL_8 = 2'h3;
   localparam logic [LEN_W-1:0] LEN_1 = 4'h1;
   localparam logic [LEN_W-1:0] LEN_2 = 4'h2;
   localparam logic [LEN_W-1:0] LEN_7 = 4'h7;
   localparam logic [LEN_W-1:0] LEN_8 = 4'h8;

   // frame counter landmarks
   localparam logic [CNT_W-1:0] FRAME_START = 9'h000;
   localparam logic [CNT_W-1:0] LAST_256 = 9'h0FF;
   localparam logic [CNT_W-1:0] LAST_512 = 9'h1FF;

   // reset and idle values
   localparam logic [BYTE_W-1:0] TX_IDLE = 8'hFF; // idle ones when no data
   localparam logic [CH_N-1:0] ACT_NONE = 4'h0;
   localparam logic MARK_IDLE_N = 1'b1; // marker released

   typedef logic [CH_N-1:0][POS_W-1:0] pos_arr_t;
   typedef logic [CH_N-1:0][WSEL_W-1:0] wsel_arr_t;
   typedef logic [CH_N-1:0][BYTE_W-1:0] tx_frame_t; // one byte per channel
   typedef logic [2*CH_N-1:0] rx_word_t; // {active mask, received bits}

   // configuration as seen by the link side
   typedef struct packed {
      logic hi;
      logic lo;
      logic dbl;
      logic f256;
      pos_arr_t pos;
      wsel_arr_t wsel;
   } cfg_t;

   // slot length for a width select code
   function automatic logic [LEN_W-1:0] slot_len(input logic [WSEL_W-1:0] sel);
      logic [LEN_W-1:0] len;
      unique case (sel)
         WSEL_1: len = LEN_1;
         WSEL_2: len = LEN_2;
         WSEL_7: len = LEN_7;
         WSEL_8: len = LEN_8;
      endcase
      return len;
   endfunction
endpackage

// File: src/tdm_slot_channel_access.sv
// slot gating of four serial channels onto a tdm highway, with domain crossings
`timescale 1ns/1ps
// Contract
// - sample rx falling edge, launch tx rising
// - bit clock equals or doubles data rate
// - one shared bit clock and frame sync
// - four separate links or one shared link
// - tx pin released outside its slot
// - 8-bit slot position, two-bit steps
// - slot width 1, 2, 7 or 8 bits
// - position and width shared by rx, tx
// - counter wraps itself at 256 or 512
// - slot marker active low, meaning per mode
// - quad slot mode marks second controller slot
// - mode bits both one select quad slots
module tdm_slot_channel_access (
   // system clock and reset
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   // highway clock, frame sync and data pins
   input wire logic serial_bit_clock_in,
   input wire logic frame_sync_in,
   input wire logic [tdm_pkg::CH_N-1:0] serial_rx_line_in,
   output logic [tdm_pkg::CH_N-1:0] serial_tx_line_out,
   output logic [tdm_pkg::CH_N-1:0] serial_tx_oe_out,
   output logic slot_marker_n_out,
   // configuration levels
   input wire logic connection_mode_hi_in,
   input wire logic connection_mode_lo_in,
   input wire logic double_rate_in,
   input wire logic frame_256_in,
   input wire tdm_pkg::pos_arr_t slot_position_reg_in,
   input wire tdm_pkg::wsel_arr_t slot_width_sel_in,
   // received bits towards the user
   output logic rx_valid_out,
   input wire logic rx_ready_in,
   output tdm_pkg::rx_word_t rx_data_out,
   output logic rx_overrun_out,
   input wire logic rx_overrun_clr_in,
   // transmit frames from the user
   input wire logic tx_valid_in,
   input wire tdm_pkg::tx_frame_t tx_data_in,
   output logic tx_ready_out
);
   import tdm_pkg::*;

   // system-side state
   typedef struct packed {
      logic rx_s1; // first stage of the rx toggle sync
      logic rx_s2;
      logic rx_seen; // last rx toggle acted on
      logic overrun; // sticky: a word arrived while the buffer was full
      logic req_s1; // first stage of the tx request sync
      logic req_s2;
      logic req_seen;
      logic ack_tgl; // flips when x_data holds a fresh frame
      logic hold_full; // user frame waiting in hold
      logic tx_ready;
      tx_frame_t hold;
      tx_frame_t x_data; // frame offered to the link side
   } sys_t;

   // link-side state
   typedef struct packed {
      cfg_t cfg1; // first stage of the config sync
      cfg_t cfg2; // config as used on the link
      logic phase; // second clock of a bit at double rate
      logic [CNT_W-1:0] cnt; // bit index of the current bit
      logic [CH_N-1:0] act; // channels owning the current bit
      logic mark_n;
      logic [CH_N-1:0] tx_line;
      logic [CH_N-1:0] tx_oe;
      rx_word_t rx_word; // bits of the last active bit time
      logic rx_tgl;
      tx_frame_t tx_pre; // prefetched frame for the next frame start
      tx_frame_t tx_frame; // frame being sent
      logic req_tgl; // asks the system side for the next frame
      logic ack_s1; // first stage of the ack sync
      logic ack_s2;
      logic ack_seen;
   } link_t;

   sys_t s, next_s;
   link_t l, next_l;
   logic [1:0] s_rst_q; // reset release chain, system clock
   logic [1:0] l_rst_q; // reset release chain, bit clock
   logic s_rst_n;
   logic l_rst_n;
   logic [CH_N-1:0] rx_smp; // pins caught on the falling edge
   cfg_t cfg_in; // configuration ports gathered
   logic rx_event; // a new rx word is stable on the link side
   logic req_event; // link side asked for the next frame
   logic [1:0] mode;
   logic cc; // strobe-driven common control mode
   logic iom; // fixed two-bit slots
   logic quad_lines; // each channel on its own pins
   logic bit_start; // this rising edge opens a new bit
   logic frame_nx; // the new bit is the first of a frame
   logic [CNT_W-1:0] cnt_nx;
   logic [CH_N-1:0] hit_w; // channels owning the new bit
   logic [CH_N-1:0][OFF_W-1:0] off_w; // bit index within each slot
   logic [CH_N-1:0] txb_w; // bit each channel sends in the new bit
   logic [CH_N-1:0] rx_bits; // received bit per active channel
   tx_frame_t fr; // frame in force for the new bit

   stream_if #(.W(2 * CH_N)) rx_in ();
   stream_if #(.W(2 * CH_N)) rx_out ();

   // release of the reset, one chain per clock domain
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         s_rst_q <= 2'h0;
      end else begin
         s_rst_q <= {s_rst_q[0], 1'b1};
      end
   end
   always_ff @(posedge serial_bit_clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         l_rst_q <= 2'h0;
      end else begin
         l_rst_q <= {l_rst_q[0], 1'b1};
      end
   end
   assign s_rst_n = s_rst_q[1];
   assign l_rst_n = l_rst_q[1];

   assign cfg_in = '{hi: connection_mode_hi_in, lo: connection_mode_lo_in,
                     dbl: double_rate_in, f256: frame_256_in,
                     pos: slot_position_reg_in, wsel: slot_width_sel_in};

   // ---- system domain ----

   // the rx word is stable for a whole bit time after its toggle flips
   assign rx_event = (s.rx_s2 != s.rx_seen);
   assign req_event = (s.req_s2 != s.req_seen);
   assign rx_in.valid = rx_event;
   assign rx_in.data = l.rx_word;
   assign rx_out.ready = rx_ready_in;

   // received words wait here while the reader stalls
   stream_buffer #(.W(2 * CH_N), .DEPTH(BUF_DEPTH)) u_rx_buf (
      .clk_in(clk_sys_in),
      .rst_n_in(s_rst_n),
      .push(rx_in.sink),
      .pop(rx_out.source)
   );

   // system next state: rx sync, overrun flag, tx hold and handover
   always_comb begin
      next_s = s;
      next_s.rx_s1 = l.rx_tgl;
      next_s.rx_s2 = s.rx_s1;
      next_s.rx_seen = s.rx_s2;
      next_s.req_s1 = l.req_tgl;
      next_s.req_s2 = s.req_s1;
      next_s.req_seen = s.req_s2;
      // the highway cannot be paused, so a full buffer can only be reported
      next_s.overrun = (rx_event & ~rx_in.ready) | (s.overrun & ~rx_overrun_clr_in);
      if (req_event) begin
         // a missing user frame is replaced by idle ones
         next_s.x_data = s.hold_full ? s.hold : {CH_N{TX_IDLE}};
         next_s.hold_full = 1'b0;
         next_s.ack_tgl = ~s.ack_tgl;
      end
      if (tx_valid_in && s.tx_ready) begin
         next_s.hold = tx_data_in;
         next_s.hold_full = 1'b1;
      end
      next_s.tx_ready = ~next_s.hold_full;
   end

   // system state register
   always_ff @(posedge clk_sys_in or negedge s_rst_n) begin
      if (!s_rst_n) begin
         s <= '0;
         s.x_data <= {CH_N{TX_IDLE}};
      end else begin
         s <= next_s;
      end
   end

   // ---- link domain ----

   // receive pins are taken on the falling edge, mid bit
   always_ff @(negedge serial_bit_clock_in or negedge l_rst_n) begin
      if (!l_rst_n) begin
         rx_smp <= ACT_NONE;
      end else begin
         rx_smp <= serial_rx_line_in;
      end
   end

   assign mode = {l.cfg2.hi, l.cfg2.lo};
   assign cc = (mode == MODE_QUAD_CC);
   assign iom = (mode == MODE_SINGLE_IOM);
   assign quad_lines = (mode == MODE_QUAD_TS) || cc;

   // at double rate a bit spans two clocks; outside common control a frame sync realigns the pair
   assign bit_start = (!cc && frame_sync_in) || !l.cfg2.dbl || l.phase;

   // next bit index: strobe count in common control, frame count otherwise
   always_comb begin
      if (cc) begin
         cnt_nx = (frame_sync_in && l.act[0]) ? CNT_W'(l.cnt + 1'b1) : FRAME_START;
      end else if (frame_sync_in) begin
         cnt_nx = FRAME_START;
      end else if (l.cfg2.f256 && l.cnt == LAST_256) begin
         cnt_nx = FRAME_START;
      end else begin
         cnt_nx = CNT_W'(l.cnt + 1'b1);
      end
   end

   assign frame_nx = (cnt_nx == FRAME_START) && (!cc || frame_sync_in);
   assign fr = frame_nx ? l.tx_pre : l.tx_frame;

   // per channel: does it own the new bit, and which of its bits goes out
   for (genvar i = 0; i < CH_N; i++) begin : g_slot
      logic [CNT_W-1:0] start; // first bit of the slot
      logic [CNT_W-1:0] off; // distance from the slot start
      logic [LEN_W-1:0] len;
      assign start = cc ? FRAME_START : {l.cfg2.pos[i], 1'b0};
      assign off = CNT_W'(cnt_nx - start);
      assign len = iom ? LEN_2 : slot_len(l.cfg2.wsel[i]);
      // one window serves both directions of the channel
      assign hit_w[i] = cc ? frame_sync_in : (off < CNT_W'(len));
      assign off_w[i] = off[OFF_W-1:0];
      assign txb_w[i] = fr[i][off_w[i]];
      assign rx_bits[i] = l.act[i] & (quad_lines ? rx_smp[i] : rx_smp[0]);
   end

   // link next state: config sync, counting, gating, crossings
   always_comb begin
      next_l = l;
      next_l.cfg1 = cfg_in;
      next_l.cfg2 = l.cfg1;
      next_l.ack_s1 = s.ack_tgl;
      next_l.ack_s2 = l.ack_s1;
      next_l.phase = l.cfg2.dbl & ~bit_start;
      if (bit_start) begin
         // hand the bits of the bit time just ended to the system side
         if (l.act != ACT_NONE) begin
            next_l.rx_word = {l.act, rx_bits};
            next_l.rx_tgl = ~l.rx_tgl;
         end
         next_l.cnt = cnt_nx;
         next_l.act = hit_w;
         // start of frame: take the prefetched frame, ask for the next
         if (frame_nx) begin
            next_l.tx_frame = l.tx_pre;
            next_l.tx_pre = {CH_N{TX_IDLE}};
            next_l.req_tgl = ~l.req_tgl;
         end
         // drive only inside a slot, released everywhere else
         if (quad_lines) begin
            next_l.tx_line = txb_w;
            next_l.tx_oe = hit_w;
         end else begin
            next_l.tx_line = {CH_N{1'b1}};
            next_l.tx_oe = ACT_NONE;
            // shared link: the lowest owning channel drives pin zero
            for (int i = CH_N - 1; i >= 0; i--) begin
               if (hit_w[i]) begin
                  next_l.tx_line[0] = txb_w[i];
               end
            end
            next_l.tx_oe[0] = (hit_w != ACT_NONE);
         end
         // marker meaning per mode, always low when active
         unique case (mode)
            MODE_QUAD_TS: next_l.mark_n = ~hit_w[MARK_CH];
            MODE_QUAD_CC: next_l.mark_n = ~frame_sync_in;
            MODE_SINGLE_TS: next_l.mark_n = ~(|hit_w);
            MODE_SINGLE_IOM: next_l.mark_n = ~(|hit_w);
         endcase
      end
      // a fresh frame from the system side is stable once its ack flips
      if (l.ack_s2 != l.ack_seen) begin
         next_l.ack_seen = l.ack_s2;
         next_l.tx_pre = s.x_data;
      end
   end

   // link state register, launching on the rising edge
   always_ff @(posedge serial_bit_clock_in or negedge l_rst_n) begin
      if (!l_rst_n) begin
         l <= '0;
         l.mark_n <= MARK_IDLE_N;
         l.tx_pre <= {CH_N{TX_IDLE}};
         l.tx_frame <= {CH_N{TX_IDLE}};
      end else begin
         l <= next_l;
      end
   end

   // outputs straight from flops
   assign serial_tx_line_out = l.tx_line;
   assign serial_tx_oe_out = l.tx_oe;
   assign slot_marker_n_out = l.mark_n;
   assign rx_valid_out = rx_out.valid;
   assign rx_data_out = rx_out.data;
   assign rx_overrun_out = s.overrun;
   assign tx_ready_out = s.tx_ready;

   // ---- checks on the link side ----
   default clocking lcb @(posedge serial_bit_clock_in); endclocking
   default disable iff (!l_rst_n);

   // a double-rate bit opened without sync
   sequence s_dbl_open;
      l.cfg2.dbl && bit_start && !frame_sync_in && !cc;
   endsequence
   // the mode was quad slots when the current outputs were formed
   sequence s_quad_ts_held;
      (mode == MODE_QUAD_TS) ##1 (mode == MODE_QUAD_TS);
   endsequence

   a_dbl_half_rate: assert property (
      s_dbl_open ##1 (!frame_sync_in && l.cfg2.dbl && !cc) |-> !bit_start)
      else $error("double rate bit advanced after one clock");
   a_wrap_512: assert property (
      (bit_start && !frame_sync_in && !cc && !l.cfg2.f256 && l.cnt == LAST_512)
      |=> (l.cnt == FRAME_START))
      else $error("counter did not wrap after bit 511");
   a_wrap_256: assert property (
      (bit_start && !frame_sync_in && !cc && l.cfg2.f256 && l.cnt == LAST_256)
      |=> (l.cnt == FRAME_START))
      else $error("counter did not wrap after bit 255");
   a_sync_restart: assert property (
      (bit_start && frame_sync_in && !cc) |=> (l.cnt == FRAME_START && !l.phase))
      else $error("frame sync did not restart the frame");
   a_slot_start: assert property (
      s_quad_ts_held ##0 $stable(l.cfg2) ##0 (l.cnt == {l.cfg2.pos[0], 1'b0})
      |-> l.act[0])
      else $error("channel 0 not active at twice its position");
   a_slot_end: assert property (
      s_quad_ts_held ##0 $stable(l.cfg2)
      ##0 (l.cnt == CNT_W'({l.cfg2.pos[0], 1'b0} + CNT_W'(slot_len(l.cfg2.wsel[0]))))
      |-> !l.act[0])
      else $error("channel 0 slot longer than its width");
   a_tx_release: assert property (
      (l.act == ACT_NONE) |-> (serial_tx_oe_out == ACT_NONE))
      else $error("transmit pin driven outside any slot");
   a_marker_b: assert property (
      s_quad_ts_held |-> (slot_marker_n_out == !l.act[MARK_CH]))
      else $error("marker does not follow the second controller slot");
   a_shared_link: assert property (
      $past(mode == MODE_SINGLE_TS) && $past(bit_start)
      |-> (serial_tx_oe_out[CH_N-1:1] == '0 && serial_tx_oe_out[0] == (l.act != ACT_NONE)))
      else $error("shared link drove a pin other than zero");
   a_rx_capture: assert property (
      (bit_start && l.act != ACT_NONE)
      |=> (l.rx_tgl != $past(l.rx_tgl) && l.rx_word[2*CH_N-1:CH_N] == $past(l.act)))
      else $error("active bit time not handed to the system side");
endmodule

// File: testbench/highway_model.sv
// partner on the pcm highway: bit clock, frame sync and receive data
`timescale 1ns/1ps
module highway_model (
   // control from the bench
   input wire logic nrst_in,
   input wire logic dbl_in,
   input wire logic sync_all_in,
   input wire logic [9:0] len_in,
   // highway pins
   output logic bclk_out,
   output logic sync_out,
   output logic [3:0] rx_out,
   // bit position seen by the bench
   output logic [8:0] k_out,
   output logic half_out,
   output logic locked_out
);
   logic st; // this edge opens a bit
   logic [8:0] kn; // bit index after this edge
   int seed = 60;
   // free running bit clock, phase unrelated to the system clock
   initial begin
      bclk_out = 1'b0;
      #5.3;
      forever #24 bclk_out = ~bclk_out;
   end
   // bit counter, sync and fresh receive bits at each bit start
   always @(posedge bclk_out or negedge nrst_in) begin
      if (!nrst_in) begin
         k_out <= 9'h000;
         half_out <= 1'b0;
         sync_out <= 1'b0;
         locked_out <= 1'b0;
         rx_out <= 4'h0;
      end else begin
         st = !dbl_in || !half_out;
         kn = (sync_out || {1'b0, k_out} == len_in - 10'h001) ? 9'h000 : k_out + 9'h001;
         if (!st) begin
            kn = k_out;
         end
         half_out <= dbl_in && st;
         locked_out <= locked_out || (sync_out && st);
         k_out <= kn;
         // a new random bit each bit time, so stale values never look valid
         if (st) begin
            rx_out <= 4'($random(seed));
         end
         // sync stands only on the edge that opens bit zero; once only unless asked
         sync_out <= (sync_all_in || !locked_out) && (!dbl_in || !st)
            && {1'b0, kn} == len_in - 10'h001;
      end
   end
endmodule

// File: testbench/tb_top.sv
// self-checking bench: slot gating on the highway, rx stream and stall
`timescale 1ns/1ps
module tb_top;
   import tdm_pkg::*;
   // stimulus, results and bookkeeping
   logic clk = 1'b0;
   logic nrst = 1'b0, hi = 1'b1, lo = 1'b1, dbl = 1'b0, f256 = 1'b1;
   logic rx_ready = 1'b0, ov_clr = 1'b0, tx_valid = 1'b0, stall = 1'b0, sync_all = 1'b0;
   logic mark_n, rx_valid, ov, tx_ready, bclk, sync, half, locked;
   logic [3:0] rx, tx_line, tx_oe, a;
   logic [8:0] k;
   logic [8:0] d [4];
   logic [9:0] len = 10'h100;
   pos_arr_t pos = '0;
   wsel_arr_t wsel = '0;
   tx_frame_t txd = '0;
   rx_word_t rx_data;
   rx_word_t q [$]; // expected rx words, oldest first
   int wl [4] = '{1, 2, 7, 8}; // slot length per width code
   int failures, compares, cycles, kept, frames;
   int seed = 60;
   always #4 clk = ~clk;
   tdm_slot_channel_access dut (
      .clk_sys_in(clk),
      .nrst_in(nrst),
      .serial_bit_clock_in(bclk),
      .frame_sync_in(sync),
      .serial_rx_line_in(rx),
      .serial_tx_line_out(tx_line),
      .serial_tx_oe_out(tx_oe),
      .slot_marker_n_out(mark_n),
      .connection_mode_hi_in(hi),
      .connection_mode_lo_in(lo),
      .double_rate_in(dbl),
      .frame_256_in(f256),
      .slot_position_reg_in(pos),
      .slot_width_sel_in(wsel),
      .rx_valid_out(rx_valid),
      .rx_ready_in(rx_ready),
      .rx_data_out(rx_data),
      .rx_overrun_out(ov),
      .rx_overrun_clr_in(ov_clr),
      .tx_valid_in(tx_valid),
      .tx_data_in(txd),
      .tx_ready_out(tx_ready)
   );
   highway_model partner (
      .nrst_in(nrst),
      .dbl_in(dbl),
      .sync_all_in(sync_all),
      .len_in(len),
      .bclk_out(bclk),
      .sync_out(sync),
      .rx_out(rx),
      .k_out(k),
      .half_out(half),
      .locked_out(locked)
   );
   task check(input logic ok, input string msg);
      compares++;
      if (ok !== 1'b1) begin
         failures++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   task conclude;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // hang guard, well above the five tests' length
   always @(posedge clk) begin
      cycles++;
      if (cycles == 80000) begin
         failures++;
         conclude();
      end
   end
   // pins of the bit now ending, and the rx word it must post
   always @(negedge bclk) begin
      if (locked && !half) begin
         for (int i = 0; i < 4; i++) begin
            d[i] = k - {pos[i], 1'b0};
            // single iom mode forces two-bit slots whatever the width code says
            a[i] = d[i] < ((hi && !lo) ? 2 : wl[wsel[i]]);
         end
         if (k == 9'h000) frames++;
         if (hi && lo) begin
            check(tx_oe === a, "enable outside slot");
            check(mark_n === !a[1], "slot marker");
         end else begin
            check(tx_oe === {3'h0, |a}, "shared link enable");
            check(mark_n === !(|a), "shared slot marker");
         end
         // data is checked only once the held frame has surely reached the link
         for (int i = 0; i < 4; i++) begin
            if (a[i] && frames > 1) begin
               check(tx_line[(hi && lo) ? i : 0] === txd[i][d[i][2:0]], "tx bit");
            end
         end
         if (!stall) kept = 0;
         // while stalled only two words fit the buffer, the rest are lost
         if (a != 4'h0 && kept < 2) begin
            q.push_back({a, ((hi && lo) ? rx : {4{rx[0]}}) & a});
            if (stall) kept++;
         end
      end
   end
   // reader: random stalls, each taken word against the oldest note
   always @(posedge clk) begin
      if (rx_valid && rx_ready && locked) begin
         if (q.size() == 0) check(1'b0, "unexpected rx word");
         else check(rx_data === q.pop_front(), "rx word");
      end
      // ready three times in four: long random stalls would overrun the buffer
      rx_ready <= !stall && (2'($random(seed)) != 2'h0);
   end
   // config only changes under reset, since it crosses bit by bit
   task run_test(input int tn, input logic [1:0] md, input logic d2, input logic w,
                 input int n, input logic all, input wsel_arr_t ws);
      @(posedge clk);
      nrst <= 1'b0;
      tx_valid <= 1'b0;
      {hi, lo} <= md;
      dbl <= d2;
      f256 <= w;
      len <= 10'(n);
      sync_all <= all;
      wsel <= ws;
      txd <= tx_frame_t'($random(seed));
      for (int i = 0; i < 4; i++) pos[i] <= 8'h04 + 8'(i * 8) + 8'($random(seed) & 3);
      repeat (30) @(posedge clk);
      q.delete();
      frames = 0;
      check({tx_ready, mark_n, tx_oe, rx_valid} === 7'h20, "outputs in reset");
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      // system side runs two edges after release, so the hold is free by now
      @(negedge clk);
      check(tx_ready === 1'b1, "tx ready after reset");
      @(posedge clk);
      tx_valid <= 1'b1;
      repeat (2) @(posedge clk);
      @(negedge clk);
      check(tx_ready === 1'b0, "tx ready while frame held");
      wait (frames == 4);
      // stall the reader for a frame, far from any slot
      if (tn == 1) begin
         wait (k == 9'h0C8);
         @(posedge clk);
         stall <= 1'b1;
         wait (k == 9'h0C7);
         check(ov === 1'b1, "overrun flag");
         @(posedge clk);
         stall <= 1'b0;
         ov_clr <= 1'b1;
         @(posedge clk);
         ov_clr <= 1'b0;
         repeat (2) @(posedge clk);
         check(ov === 1'b0, "overrun clear");
      end
      wait (k == 9'h096);
      check(q.size() == 0, "rx words missing");
      $display("test %0d done", tn);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      run_test(1, MODE_QUAD_TS, 1'b0, 1'b1, 256, 1'b0, wsel_arr_t'(8'hE4));
      run_test(2, MODE_QUAD_TS, 1'b1, 1'b1, 256, 1'b0, wsel_arr_t'(8'($random(seed))));
      run_test(3, MODE_SINGLE_TS, 1'b0, 1'b0, 200, 1'b1, wsel_arr_t'(8'($random(seed))));
      run_test(4, MODE_QUAD_TS, 1'b0, 1'b0, 512, 1'b0, wsel_arr_t'(8'($random(seed))));
      run_test(5, MODE_SINGLE_IOM, 1'b0, 1'b0, 200, 1'b1, wsel_arr_t'(8'($random(seed))));
      conclude();
   end
endmodule
